// >>> hdl/msq_pkg.sv
// Shared constants and types of the microprogram address sequencer
package msq_pkg;
   // ****************************************
   // Widths and sizes
   // ****************************************
   localparam int ADDR_W = 12;
   localparam int STACK_DEPTH = 9;
   localparam int LEVEL_W = 4;
   localparam int INSTR_W = 4;
   localparam int REG_AW = 4;
   localparam int REG_DW = 32;
   localparam int EVT_W = 4;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [REG_AW-1:0] OFS_STATUS = 4'h0;
   localparam logic [REG_AW-1:0] OFS_MASK = 4'h4;
   localparam logic [REG_AW-1:0] OFS_STATE = 4'h8;
   localparam logic [REG_AW-1:0] OFS_COUNT = 4'hc;
   localparam logic [EVT_W-1:0] STATUS_RST = 4'h0;
   localparam logic [EVT_W-1:0] MASK_RST = 4'h0;

   // ****************************************
   // Event bits in status and mask
   // ****************************************
   localparam int EVT_OVF = 0;
   localparam int EVT_UNF = 1;
   localparam int EVT_ZERO = 2;
   localparam int EVT_FULL = 3;

   // ****************************************
   // Fields of the state register
   // ****************************************
   localparam int ST_LEVEL_LSB = 0;
   localparam int ST_ZERO = 4;
   localparam int ST_FULL = 5;
   localparam int ST_EMPTY = 6;

   // ****************************************
   // Opcodes, sources, counter commands
   // ****************************************
   typedef enum logic [INSTR_W-1:0] {
      OP_JZ = 4'h0, OP_CJS = 4'h1, OP_JMAP = 4'h2, OP_CJP = 4'h3,
      OP_PUSH = 4'h4, OP_JSRP = 4'h5, OP_CJV = 4'h6, OP_JRP = 4'h7,
      OP_RFCT = 4'h8, OP_RPCT = 4'h9, OP_CRTN = 4'ha, OP_CJPP = 4'hb,
      OP_LDCT = 4'hc, OP_LOOP = 4'hd, OP_CONT = 4'he, OP_TWB = 4'hf
   } msq_op_t;

   typedef enum logic [1:0] {
      SRC_REG = 2'h0, SRC_DATA = 2'h1, SRC_PC = 2'h2, SRC_STACK = 2'h3
   } msq_src_t;

   typedef enum logic [1:0] {
      CNT_HOLD = 2'h0, CNT_LOAD = 2'h1, CNT_DEC = 2'h2
   } msq_cnt_t;

   typedef enum logic [1:0] {
      BR_PIPE = 2'h0, BR_MAP = 2'h1, BR_VECT = 2'h2
   } msq_br_t;
endpackage : msq_pkg

// >>> hdl/msq_stack_if.sv
// Link between the sequencer core and its return-address stack
`timescale 1ns/1ps
`default_nettype none
interface msq_stack_if;
   import msq_pkg::*;
   logic push;
   logic pop;
   logic clear;
   logic [ADDR_W-1:0] push_data;
   logic [ADDR_W-1:0] top;
   logic [LEVEL_W-1:0] level;
   logic full;
   logic empty;
   logic overflow;
   logic underflow;

   modport ctl (output push, pop, clear, push_data,
                input top, level, full, empty, overflow, underflow);
   modport stk (input push, pop, clear, push_data,
                output top, level, full, empty, overflow, underflow);
endinterface : msq_stack_if
`default_nettype wire

// >>> hdl/msq_stack.sv
// Nine-deep return-address stack
`timescale 1ns/1ps
`default_nettype none
module msq_stack #(
   parameter int DEPTH = msq_pkg::STACK_DEPTH
) (
   input wire logic clock,
   input wire logic nrst,
   msq_stack_if.stk sif
);
   import msq_pkg::*;

   logic [ADDR_W-1:0] mem_ff [DEPTH];
   logic [ADDR_W-1:0] nxt_mem [DEPTH];
   logic [LEVEL_W-1:0] cnt_ff;
   logic [LEVEL_W-1:0] nxt_cnt;

   // Index of the top entry, 0 when the stack is empty
   function automatic logic [LEVEL_W-1:0] last_idx(input logic [LEVEL_W-1:0] c);
      last_idx = (c == '0) ? '0 : c - 4'h1;
   endfunction : last_idx

   // ****************************************
   // Status
   // ****************************************
   assign sif.level = cnt_ff;
   assign sif.full = (cnt_ff == LEVEL_W'(DEPTH));
   assign sif.empty = (cnt_ff == '0);
   assign sif.top = mem_ff[last_idx(cnt_ff)];
   assign sif.overflow = sif.push & sif.full;
   assign sif.underflow = sif.pop & sif.empty;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_mem = mem_ff;
      nxt_cnt = cnt_ff;
      if (sif.clear) begin
         nxt_cnt = '0;
      end else if (sif.push) begin
         if (sif.full) begin
            nxt_mem[DEPTH-1] = sif.push_data;
         end else begin
            nxt_mem[cnt_ff] = sif.push_data;
            nxt_cnt = cnt_ff + 4'h1;
         end
      end else if (sif.pop && !sif.empty) begin
         nxt_cnt = cnt_ff - 4'h1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else begin
         cnt_ff <= nxt_cnt;
         mem_ff <= nxt_mem;
      end
   end
endmodule : msq_stack
`default_nettype wire

// >>> hdl/msq_top.sv
// Microprogram address sequencer with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module msq_top (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [msq_pkg::INSTR_W-1:0] instr_code,
   input wire logic cond_code_n,
   input wire logic cond_enable_n,
   input wire logic counter_load_n,
   input wire logic inc_carry_in,
   input wire logic addr_drive_n,
   input wire logic [msq_pkg::ADDR_W-1:0] data_in,
   output logic [msq_pkg::ADDR_W-1:0] y_out,
   output logic y_oe,
   output logic pipe_src_en_n,
   output logic map_src_en_n,
   output logic vector_src_en_n,
   output logic stack_full_n,
   input wire logic [msq_pkg::REG_AW-1:0] reg_addr,
   input wire logic [msq_pkg::REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [msq_pkg::REG_DW-1:0] reg_rdata,
   output logic irq
);
   import msq_pkg::*;

   localparam int PIN_W = INSTR_W + 5 + ADDR_W;
   // Pin levels assumed in reset, both sync stages alike
   localparam logic [PIN_W-1:0] PIN_IDLE = {{INSTR_W{1'b0}}, 5'h1f, {ADDR_W{1'b0}}};

   // ****************************************
   // Declarations
   // ****************************************
   logic [PIN_W-1:0] pins;
   logic [PIN_W-1:0] sync1_ff;
   logic [PIN_W-1:0] sync2_ff;
   logic [PIN_W-1:0] nxt_sync1;
   logic [PIN_W-1:0] nxt_sync2;
   msq_op_t op;
   logic cc_n_s;
   logic cce_n_s;
   logic ld_n_s;
   logic ci_s;
   logic oe_n_s;
   logic [ADDR_W-1:0] data_s;

   logic [ADDR_W-1:0] cnt_ff;
   logic [ADDR_W-1:0] nxt_cnt;
   logic [ADDR_W-1:0] upc_ff;
   logic [ADDR_W-1:0] nxt_upc;
   logic zero_seen_ff;
   logic nxt_zero_seen;
   logic full_seen_ff;
   logic nxt_full_seen;

   logic fail;
   logic pass;
   logic cnt_zero;
   msq_src_t src;
   msq_cnt_t cnt_cmd;
   msq_br_t br;
   logic do_push;
   logic do_pop;
   logic do_clear;
   logic [ADDR_W-1:0] y_next;

   logic [EVT_W-1:0] status_ff;
   logic [EVT_W-1:0] nxt_status;
   logic [EVT_W-1:0] mask_ff;
   logic [EVT_W-1:0] nxt_mask;
   logic [REG_DW-1:0] rdata_ff;
   logic [REG_DW-1:0] nxt_rdata;
   logic [EVT_W-1:0] events;

   msq_stack_if sif ();

   // ****************************************
   // Pin synchronisers
   // ****************************************
   assign pins = {instr_code, cond_code_n, cond_enable_n, counter_load_n,
                  inc_carry_in, addr_drive_n, data_in};

   always_comb begin
      nxt_sync1 = pins;
      nxt_sync2 = sync1_ff;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_ff <= PIN_IDLE;
         sync2_ff <= PIN_IDLE;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
      end
   end

   assign op = msq_op_t'(sync2_ff[PIN_W-1 -: INSTR_W]);
   assign cc_n_s = sync2_ff[ADDR_W+4];
   assign cce_n_s = sync2_ff[ADDR_W+3];
   assign ld_n_s = sync2_ff[ADDR_W+2];
   assign ci_s = sync2_ff[ADDR_W+1];
   assign oe_n_s = sync2_ff[ADDR_W];
   assign data_s = sync2_ff[ADDR_W-1:0];

   // ****************************************
   // Condition and zero detect
   // ****************************************
   assign fail = cce_n_s | ~cc_n_s;
   assign pass = ~fail;
   assign cnt_zero = (cnt_ff == '0);

   // ****************************************
   // Instruction decoder
   // ****************************************
   always_comb begin
      src = SRC_PC;
      cnt_cmd = CNT_HOLD;
      br = BR_PIPE;
      do_push = 1'b0;
      do_pop = 1'b0;
      do_clear = 1'b0;
      case (op)
         OP_JZ: begin
            src = SRC_DATA;
            do_clear = 1'b1;
         end
         OP_CJS: begin
            src = pass ? SRC_DATA : SRC_PC;
            do_push = pass;
         end
         OP_JMAP: begin
            src = SRC_DATA;
            br = BR_MAP;
         end
         OP_CJP: begin
            src = pass ? SRC_DATA : SRC_PC;
         end
         OP_PUSH: begin
            do_push = 1'b1;
            cnt_cmd = pass ? CNT_LOAD : CNT_HOLD;
         end
         OP_JSRP: begin
            src = pass ? SRC_DATA : SRC_REG;
            do_push = 1'b1;
         end
         OP_CJV: begin
            src = pass ? SRC_DATA : SRC_PC;
            br = BR_VECT;
         end
         OP_JRP: begin
            src = pass ? SRC_DATA : SRC_REG;
         end
         OP_RFCT: begin
            if (!cnt_zero) begin
               src = SRC_STACK;
               cnt_cmd = CNT_DEC;
            end else begin
               do_pop = 1'b1;
            end
         end
         OP_RPCT: begin
            if (!cnt_zero) begin
               src = SRC_DATA;
               cnt_cmd = CNT_DEC;
            end
         end
         OP_CRTN: begin
            src = pass ? SRC_STACK : SRC_PC;
            do_pop = pass;
         end
         OP_CJPP: begin
            src = pass ? SRC_DATA : SRC_PC;
            do_pop = pass;
         end
         OP_LDCT: begin
            cnt_cmd = CNT_LOAD;
         end
         OP_LOOP: begin
            src = pass ? SRC_PC : SRC_STACK;
            do_pop = pass;
         end
         OP_CONT: begin
            src = SRC_PC;
         end
         OP_TWB: begin
            if (pass) begin
               do_pop = 1'b1;
            end else if (!cnt_zero) begin
               src = SRC_STACK;
               cnt_cmd = CNT_DEC;
            end else begin
               src = SRC_DATA;
               do_pop = 1'b1;
            end
         end
         default: begin
            src = SRC_PC;
         end
      endcase
   end

   // ****************************************
   // Branch source enables
   // ****************************************
   assign pipe_src_en_n = (br != BR_PIPE);
   assign map_src_en_n = (br != BR_MAP);
   assign vector_src_en_n = (br != BR_VECT);

   // ****************************************
   // Address selector and output
   // ****************************************
   always_comb begin
      case (src)
         SRC_REG: y_next = cnt_ff;
         SRC_DATA: y_next = (op == OP_JZ) ? '0 : data_s;
         SRC_PC: y_next = upc_ff;
         SRC_STACK: y_next = sif.top;
         default: y_next = upc_ff;
      endcase
   end

   assign y_out = y_next;
   assign y_oe = ~oe_n_s;

   // ****************************************
   // Stack
   // ****************************************
   assign sif.push = do_push;
   assign sif.pop = do_pop;
   assign sif.clear = do_clear;
   assign sif.push_data = upc_ff;
   assign stack_full_n = ~sif.full;

   msq_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .clock(clock),
      .nrst(nrst),
      .sif(sif)
   );

   // ****************************************
   // Counter and micro_pc
   // ****************************************
   always_comb begin
      nxt_cnt = cnt_ff;
      if (!ld_n_s) begin
         nxt_cnt = data_s;
      end else begin
         case (cnt_cmd)
            CNT_LOAD: nxt_cnt = data_s;
            CNT_DEC: nxt_cnt = cnt_ff - 12'h001;
            default: nxt_cnt = cnt_ff;
         endcase
      end
      nxt_upc = y_next + {{(ADDR_W-1){1'b0}}, ci_s};
      nxt_zero_seen = cnt_zero;
      nxt_full_seen = sif.full;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
         upc_ff <= '0;
         zero_seen_ff <= 1'b1;
         full_seen_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         upc_ff <= nxt_upc;
         zero_seen_ff <= nxt_zero_seen;
         full_seen_ff <= nxt_full_seen;
      end
   end

   // ****************************************
   // Register port and interrupt
   // ****************************************
   always_comb begin
      events = '0;
      events[EVT_OVF] = sif.overflow;
      events[EVT_UNF] = sif.underflow;
      events[EVT_ZERO] = cnt_zero & ~zero_seen_ff;
      events[EVT_FULL] = sif.full & ~full_seen_ff;
      nxt_status = status_ff;
      nxt_mask = mask_ff;
      if (reg_wr && reg_addr == OFS_STATUS) begin
         nxt_status = status_ff & ~reg_wdata[EVT_W-1:0];
      end
      if (reg_wr && reg_addr == OFS_MASK) begin
         nxt_mask = reg_wdata[EVT_W-1:0];
      end
      nxt_status = nxt_status | events;
      nxt_rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            OFS_STATUS: nxt_rdata[EVT_W-1:0] = status_ff;
            OFS_MASK: nxt_rdata[EVT_W-1:0] = mask_ff;
            OFS_STATE: begin
               nxt_rdata[ST_LEVEL_LSB +: LEVEL_W] = sif.level;
               nxt_rdata[ST_ZERO] = cnt_zero;
               nxt_rdata[ST_FULL] = sif.full;
               nxt_rdata[ST_EMPTY] = sif.empty;
            end
            OFS_COUNT: nxt_rdata[ADDR_W-1:0] = cnt_ff;
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_ff <= STATUS_RST;
         mask_ff <= MASK_RST;
         rdata_ff <= '0;
      end else begin
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
   assign irq = |(status_ff & mask_ff);
endmodule : msq_top
`default_nettype wire

// >>> verification/msq_top_monitor.sv
// Checker of the sequencer pins and register port
`timescale 1ns/1ps
`default_nettype none
module msq_top_monitor (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [msq_pkg::INSTR_W-1:0] instr_code,
   input wire logic inc_carry_in,
   input wire logic addr_drive_n,
   input wire logic [msq_pkg::ADDR_W-1:0] y_out,
   input wire logic y_oe,
   input wire logic pipe_src_en_n,
   input wire logic map_src_en_n,
   input wire logic vector_src_en_n,
   input wire logic stack_full_n,
   input wire logic [msq_pkg::REG_AW-1:0] reg_addr,
   input wire logic [msq_pkg::REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [msq_pkg::REG_DW-1:0] reg_rdata,
   input wire logic irq
);
   import msq_pkg::*;
   // ****
   // Helper state
   // ****
   logic [3:0] cyc_ff;
   logic [3:0] nxt_cyc;
   logic [EVT_W-1:0] mask_ff;
   logic [EVT_W-1:0] nxt_mask;
   always_comb begin
      nxt_cyc = (cyc_ff == 4'hf) ? cyc_ff : cyc_ff + 4'h1;
      nxt_mask = (reg_wr && reg_addr == OFS_MASK) ? reg_wdata[EVT_W-1:0] : mask_ff;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cyc_ff <= 4'h0;
         mask_ff <= MASK_RST;
      end else begin
         cyc_ff <= nxt_cyc;
         mask_ff <= nxt_mask;
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_inc; (instr_code == OP_CONT && inc_carry_in)[*6]; endsequence
   sequence s_hold; (instr_code == OP_CONT && !inc_carry_in)[*6]; endsequence
   sequence s_jz; (instr_code == OP_JZ)[*4]; endsequence
   sequence s_jmap; (instr_code == OP_JMAP)[*3]; endsequence
   sequence s_cjv; (instr_code == OP_CJV)[*3]; endsequence
   sequence s_mask_rd; reg_rd && reg_addr == OFS_MASK; endsequence
   property p_inc; s_inc |-> y_out == $past(y_out) + 12'h001; endproperty
   property p_hold; s_hold |-> $stable(y_out); endproperty
   property p_jz; s_jz |-> y_out == 12'h000; endproperty
   property p_one; $countones({pipe_src_en_n, map_src_en_n, vector_src_en_n}) == 2; endproperty
   property p_map; s_jmap |-> !map_src_en_n && pipe_src_en_n; endproperty
   property p_vect; s_cjv |-> !vector_src_en_n && pipe_src_en_n; endproperty
   property p_drive; cyc_ff >= 4'h3 |-> y_oe == !$past(addr_drive_n, 2); endproperty
   property p_full; $fell(stack_full_n) |-> cyc_ff >= 4'ha; endproperty
   property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   property p_unmap; reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0; endproperty
   property p_mask; s_mask_rd |=> reg_rdata == {28'h0, mask_ff}; endproperty
   property p_irq; mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> !irq; endproperty
   a_inc: assert property (p_inc) else $error("address did not step");
   a_hold: assert property (p_hold) else $error("address did not repeat");
   a_jz: assert property (p_jz) else $error("zero jump wrong");
   a_one: assert property (p_one) else $error("source enables not one low");
   a_map: assert property (p_map) else $error("map enable wrong");
   a_vect: assert property (p_vect) else $error("vector enable wrong");
   a_drive: assert property (p_drive) else $error("drive enable wrong");
   a_full: assert property (p_full) else $error("full too early");
   a_idle: assert property (p_idle) else $error("read data not idle");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_mask: assert property (p_mask) else $error("mask readback wrong");
   a_irq: assert property (p_irq) else $error("irq while masked");
endmodule : msq_top_monitor

bind msq_top msq_top_monitor i_mon (.clock(clock), .nrst(nrst), .instr_code(instr_code),
   .inc_carry_in(inc_carry_in), .addr_drive_n(addr_drive_n), .y_out(y_out), .y_oe(y_oe),
   .pipe_src_en_n(pipe_src_en_n), .map_src_en_n(map_src_en_n),
   .vector_src_en_n(vector_src_en_n), .stack_full_n(stack_full_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

// >>> verification/msq_branch_src.sv
// Branch address sources on the direct data bus
`timescale 1ns/1ps
`default_nettype none
module msq_branch_src (
   input wire logic [msq_pkg::ADDR_W-1:0] br_addr,
   input wire logic pipe_src_en_n,
   input wire logic map_src_en_n,
   input wire logic vector_src_en_n,
   output logic [msq_pkg::ADDR_W-1:0] data_in
);
   import msq_pkg::*;
   // Undriven bus shows the inverse
   always_comb begin
      case ({pipe_src_en_n, map_src_en_n, vector_src_en_n})
         3'b011: data_in = br_addr;
         3'b101: data_in = br_addr ^ 12'h0f0;
         3'b110: data_in = br_addr ^ 12'h00f;
         default: data_in = ~br_addr;
      endcase
   end
endmodule : msq_branch_src
`default_nettype wire

// >>> verification/msq_top_tb_top.sv
// Self-checking bench of the address sequencer
`timescale 1ns/1ps
`default_nettype none
module msq_top_tb_top;
   import msq_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [INSTR_W-1:0] instr_code = 4'h0;
   logic cond_code_n = 1'b1;
   logic cond_enable_n = 1'b1;
   logic counter_load_n = 1'b1;
   logic inc_carry_in = 1'b1;
   logic addr_drive_n = 1'b1;
   logic [ADDR_W-1:0] br_addr = 12'h000;
   logic [ADDR_W-1:0] data_in;
   logic [ADDR_W-1:0] y_out;
   logic [ADDR_W-1:0] y0;
   logic y_oe, pipe_src_en_n, map_src_en_n, vector_src_en_n, stack_full_n, irq;
   logic [REG_AW-1:0] reg_addr = 4'h0;
   logic [REG_DW-1:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [REG_DW-1:0] reg_rdata;
   logic [REG_DW-1:0] d;
   int mismatches = 0;
   int n_tests = 0;
   msq_op_t ops[3] = '{OP_CJP, OP_JMAP, OP_CJV};
   logic [2:0] ens[3] = '{3'b011, 3'b101, 3'b110};
   logic [ADDR_W-1:0] xs[3] = '{12'h000, 12'h0f0, 12'h00f};
   always #12.5 clock = ~clock;
   msq_top i_dut (.clock(clock), .nrst(nrst), .instr_code(instr_code),
      .cond_code_n(cond_code_n), .cond_enable_n(cond_enable_n),
      .counter_load_n(counter_load_n), .inc_carry_in(inc_carry_in),
      .addr_drive_n(addr_drive_n), .data_in(data_in), .y_out(y_out), .y_oe(y_oe),
      .pipe_src_en_n(pipe_src_en_n), .map_src_en_n(map_src_en_n),
      .vector_src_en_n(vector_src_en_n), .stack_full_n(stack_full_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq));
   msq_branch_src i_src (.br_addr(br_addr), .pipe_src_en_n(pipe_src_en_n),
      .map_src_en_n(map_src_en_n), .vector_src_en_n(vector_src_en_n), .data_in(data_in));
   // ****
   // Tasks
   // ****
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [REG_AW-1:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   task run(input msq_op_t op, input logic ci, input int n);
      @(posedge clock);
      instr_code <= op;
      inc_carry_in <= ci;
      repeat (n) @(posedge clock);
      #1;
   endtask : run
   task seq_step(input msq_op_t op, input logic ci);
      run(op, ci, 4);
      y0 = y_out;
      @(posedge clock);
      #1;
      check(y_out, y0 + {11'h0, ci});
   endtask : seq_step
   task results;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // ****
   // Tests
   // ****
   initial begin
      repeat (3000) @(posedge clock);
      mismatches++;
      results();
   end
   initial begin
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      #1;
      check(y_oe, 1'b0);
      check(stack_full_n, 1'b1);
      check(pipe_src_en_n, 1'b0);
      @(posedge clock);
      addr_drive_n <= 1'b0;
      cond_enable_n <= 1'b0;
      br_addr <= 12'h5a3;
      run(OP_JZ, 1'b1, 5);
      check(y_out, 12'h000);
      check(y_oe, 1'b1);
      seq_step(OP_CONT, 1'b1);
      seq_step(OP_CONT, 1'b0);
      @(posedge clock);
      cond_code_n <= 1'b0;
      seq_step(OP_CJP, 1'b1);
      @(posedge clock);
      cond_code_n <= 1'b1;
      cond_enable_n <= 1'b1;
      seq_step(OP_CJP, 1'b1);
      @(posedge clock);
      cond_enable_n <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         run(ops[i], 1'b1, 5);
         check({pipe_src_en_n, map_src_en_n, vector_src_en_n}, ens[i]);
         check(y_out, br_addr ^ xs[i]);
      end
      $display("test sequencing done");
      @(posedge clock);
      br_addr <= 12'h007;
      run(OP_LDCT, 1'b1, 5);
      rd(OFS_COUNT);
      check(d, 32'h7);
      @(posedge clock);
      counter_load_n <= 1'b0;
      br_addr <= 12'h123;
      run(OP_CONT, 1'b1, 5);
      rd(OFS_COUNT);
      check(d, 32'h123);
      @(posedge clock);
      br_addr <= 12'h000;
      run(OP_CONT, 1'b1, 5);
      rd(OFS_STATE);
      check(d[ST_ZERO], 1'b1);
      @(posedge clock);
      counter_load_n <= 1'b1;
      $display("test counter done");
      wr(OFS_MASK, 32'h1);
      rd(OFS_MASK);
      check(d, 32'h1);
      run(OP_JZ, 1'b1, 5);
      run(OP_PUSH, 1'b1, 14);
      check(stack_full_n, 1'b0);
      run(OP_CONT, 1'b1, 4);
      rd(OFS_STATE);
      check(d, 32'h39);
      rd(OFS_STATUS);
      check(d[EVT_OVF], 1'b1);
      check(irq, 1'b1);
      wr(OFS_STATUS, 32'hf);
      rd(OFS_STATUS);
      check(d, 32'h0);
      check(irq, 1'b0);
      run(OP_CRTN, 1'b1, 14);
      run(OP_CONT, 1'b1, 4);
      rd(OFS_STATE);
      check(d, 32'h50);
      rd(OFS_STATUS);
      check(d[EVT_UNF], 1'b1);
      check(irq, 1'b0);
      rd(4'h2);
      check(d, 32'h0);
      $display("test stack and registers done");
      // One push of micro_pc, then loop on the top entry without a pop
      run(OP_JZ, 1'b1, 5);
      @(posedge clock);
      instr_code <= OP_PUSH;
      cond_enable_n <= 1'b1;
      run(OP_LOOP, 1'b1, 5);
      check(y_out, 12'h001);
      rd(OFS_STATE);
      check(d, 32'h11);
      $display("test loop done");
      results();
   end
endmodule : msq_top_tb_top
`default_nettype wire
